// >>> logic/sqc_pkg.sv
// Package: register map, reset values and output bundle of the quad control bank
package sqc_pkg;
    localparam int AW = 20;
    localparam int IW = 18;
    // Register indices; byte address is four times the index
    localparam logic [IW-1:0] IDX_GLOBAL = 18'h30005;
    localparam logic [IW-1:0] IDX_TEST_SEL = 18'h30006;
    localparam logic [IW-1:0] IDX_BSYNC_LOCK = 18'h30800;
    localparam logic [IW-1:0] IDX_LOOP_WALIGN = 18'h30801;
    localparam logic [IW-1:0] IDX_REALIGN_MC = 18'h30810;
    localparam logic [IW-1:0] IDX_SYNC_MODE = 18'h30811;
    localparam logic [IW-1:0] IDX_RESYNC_LINK = 18'h30820;
    localparam logic [IW-1:0] IDX_LOCK_STAT = 18'h30840;
    localparam logic [AW-1:0] ADDR_GLOBAL = {IDX_GLOBAL, 2'b00};
    localparam logic [AW-1:0] ADDR_TEST_SEL = {IDX_TEST_SEL, 2'b00};
    localparam logic [AW-1:0] ADDR_BSYNC_LOCK = {IDX_BSYNC_LOCK, 2'b00};
    localparam logic [AW-1:0] ADDR_LOOP_WALIGN = {IDX_LOOP_WALIGN, 2'b00};
    localparam logic [AW-1:0] ADDR_REALIGN_MC = {IDX_REALIGN_MC, 2'b00};
    localparam logic [AW-1:0] ADDR_SYNC_MODE = {IDX_SYNC_MODE, 2'b00};
    localparam logic [AW-1:0] ADDR_RESYNC_LINK = {IDX_RESYNC_LINK, 2'b00};
    localparam logic [AW-1:0] ADDR_LOCK_STAT = {IDX_LOCK_STAT, 2'b00};
    // Global and resync register field positions
    localparam int GLB_RX_PD = 4;
    localparam int GLB_RES_LO = 5;
    localparam int GLB_RES_HI = 6;
    localparam int GLB_TEST = 7;
    localparam int RSY_PAIR_AB = 4;
    localparam int RSY_PAIR_CD = 5;
    localparam int RSY_GROUP = 6;
    localparam int RSY_XAUI = 7;
    localparam int TSEL_W = 5;
    // Reset values
    localparam logic [7:0] RST_GLOBAL = 8'h60;
    localparam logic [TSEL_W-1:0] RST_TEST_SEL = 5'h00;
    localparam logic [7:0] RST_REG8 = 8'h00;
    // Sync mode codes, first printed digit in the low bit
    localparam logic [1:0] SYNC_NONE = 2'h0;
    localparam logic [1:0] SYNC_TWIN = 2'h1;
    localparam logic [1:0] SYNC_QUAD = 2'h2;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [3:0] rx_powerdown;
        logic [3:0] test_mode_on;
        logic [TSEL_W-1:0] test_select_field;
        logic [3:0] byte_sync_enable;
        logic [3:0] pll_lock_source;
        logic [3:0] lock_indicator;
        logic [3:0] serial_loopback_on;
        logic [3:0] hs_serial_out_enable;
        logic [3:0] word_align_disable;
        logic [3:0] word_realign_pulse;
        logic [3:0] multichannel_align_enable;
        logic [7:0] alignment_sync_mode;
        logic [3:0] fifo_ptr_reset;
        logic [1:0] pair_resync;
        logic group_resync;
        logic [3:0] xaui_link_machine;
    } sqc_ctrl_t;
endpackage : sqc_pkg

// >>> logic/sqc_regs.sv
// Quad transceiver control register bank behind an AXI4-Lite slave
`timescale 1ns/100ps
`default_nettype none
module sqc_regs
    import sqc_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write channels
    input wire logic [AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels
    input wire logic [AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Per-channel settings from the channel registers
    input wire logic [3:0] channel_rx_powerdown,
    input wire logic [3:0] channel_test_enable,
    input wire logic [3:0] channel_link_machine_select,
    // Raw receiver PLL lock from the transceivers
    input wire logic [3:0] pll_locked_raw,
    // Quad control outputs
    output sqc_ctrl_t ctrl
);

    logic aw_held_ff;
    logic w_held_ff;
    logic [AW-1:0] awaddr_ff;
    logic [7:0] wbyte_ff;
    logic wlane_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [1:0] rresp_ff;
    logic [31:0] rdata_ff;
    logic do_wr;
    logic wr_hit;
    logic rd_hit;
    logic [31:0] rd_word;

    logic [7:0] global_ff;
    logic [TSEL_W-1:0] test_sel_ff;
    logic [7:0] bsync_lock_ff;
    logic [7:0] loop_walign_ff;
    logic [7:0] realign_mc_ff;
    logic [7:0] sync_mode_ff;
    logic [7:0] resync_link_ff;
    logic [10:0] trig_prev_ff;
    logic [10:0] trig_now;
    logic [10:0] trig_rise;
    sqc_ctrl_t ctrl_ff;
    logic [3:0] nxt_ptr_reset;

    // Write path: address and data are taken independently
    assign s_axi_awready = !aw_held_ff;
    assign s_axi_wready = !w_held_ff;
    assign do_wr = aw_held_ff && w_held_ff && !bvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            awaddr_ff <= '0;
        end else if (s_axi_awvalid && !aw_held_ff) begin
            aw_held_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
        end else if (do_wr) begin
            aw_held_ff <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_ff <= 1'b0;
            wbyte_ff <= '0;
            wlane_ff <= 1'b0;
        end else if (s_axi_wvalid && !w_held_ff) begin
            w_held_ff <= 1'b1;
            wbyte_ff <= s_axi_wdata[7:0];
            wlane_ff <= s_axi_wstrb[0];
        end else if (do_wr) begin
            w_held_ff <= 1'b0;
        end
    end

    always_comb begin
        case (awaddr_ff)
            ADDR_GLOBAL, ADDR_TEST_SEL, ADDR_BSYNC_LOCK, ADDR_LOOP_WALIGN,
            ADDR_REALIGN_MC, ADDR_SYNC_MODE, ADDR_RESYNC_LINK: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end else if (do_wr) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // Read path: one word per request, unmapped reads give zero and an error
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rresp = rresp_ff;
    assign s_axi_rdata = rdata_ff;

    always_comb begin
        rd_hit = 1'b1;
        case (s_axi_araddr)
            ADDR_GLOBAL: rd_word = {24'h0, global_ff[7:4], 4'h0};
            ADDR_TEST_SEL: rd_word = {27'h0, test_sel_ff};
            ADDR_BSYNC_LOCK: rd_word = {24'h0, bsync_lock_ff};
            ADDR_LOOP_WALIGN: rd_word = {24'h0, loop_walign_ff};
            ADDR_REALIGN_MC: rd_word = {24'h0, realign_mc_ff};
            ADDR_SYNC_MODE: rd_word = {24'h0, sync_mode_ff};
            ADDR_RESYNC_LINK: rd_word = {24'h0, resync_link_ff};
            ADDR_LOCK_STAT: rd_word = {28'h0, ctrl_ff.lock_indicator};
            default: begin
                rd_word = 32'h0;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rresp_ff <= RESP_OKAY;
            rdata_ff <= '0;
        end else if (s_axi_arvalid && !rvalid_ff) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            rdata_ff <= rd_word;
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // Register storage; only byte lane 0 carries data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            global_ff <= RST_GLOBAL;
        end else if (do_wr && wlane_ff && awaddr_ff == ADDR_GLOBAL) begin
            global_ff <= {wbyte_ff[7:4], 4'h0};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            test_sel_ff <= RST_TEST_SEL;
        end else if (do_wr && wlane_ff && awaddr_ff == ADDR_TEST_SEL) begin
            test_sel_ff <= wbyte_ff[TSEL_W-1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bsync_lock_ff <= RST_REG8;
        end else if (do_wr && wlane_ff && awaddr_ff == ADDR_BSYNC_LOCK) begin
            bsync_lock_ff <= wbyte_ff;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            loop_walign_ff <= RST_REG8;
        end else if (do_wr && wlane_ff && awaddr_ff == ADDR_LOOP_WALIGN) begin
            loop_walign_ff <= wbyte_ff;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            realign_mc_ff <= RST_REG8;
        end else if (do_wr && wlane_ff && awaddr_ff == ADDR_REALIGN_MC) begin
            realign_mc_ff <= wbyte_ff;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_mode_ff <= RST_REG8;
        end else if (do_wr && wlane_ff && awaddr_ff == ADDR_SYNC_MODE) begin
            sync_mode_ff <= wbyte_ff;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            resync_link_ff <= RST_REG8;
        end else if (do_wr && wlane_ff && awaddr_ff == ADDR_RESYNC_LINK) begin
            resync_link_ff <= wbyte_ff;
        end
    end

    // Trigger bits stay as written; edges against last cycle give pulses
    assign trig_now = {resync_link_ff[6:0], realign_mc_ff[3:0]};
    assign trig_rise = trig_now & ~trig_prev_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trig_prev_ff <= '0;
        end else begin
            trig_prev_ff <= trig_now;
        end
    end

    // Each channel resets on its own, its pair or the group
    for (genvar c = 0; c < 4; c++) begin : g_chan
        assign nxt_ptr_reset[c] = trig_rise[4 + c]
            | trig_rise[8 + c / 2]
            | trig_rise[10];
    end

    // Outputs from flops so the transceiver sees glitch-free controls
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff <= '0;
        end else begin
            ctrl_ff.rx_powerdown <= {4{global_ff[GLB_RX_PD]}} | channel_rx_powerdown;
            ctrl_ff.test_mode_on <= global_ff[GLB_TEST] ? 4'hf : channel_test_enable;
            ctrl_ff.test_select_field <= test_sel_ff;
            ctrl_ff.byte_sync_enable <= bsync_lock_ff[3:0];
            ctrl_ff.pll_lock_source <= bsync_lock_ff[7:4];
            ctrl_ff.lock_indicator <= pll_locked_raw & bsync_lock_ff[7:4];
            ctrl_ff.serial_loopback_on <= loop_walign_ff[3:0];
            ctrl_ff.hs_serial_out_enable <= ~loop_walign_ff[3:0];
            ctrl_ff.word_align_disable <= loop_walign_ff[7:4];
            ctrl_ff.word_realign_pulse <= trig_rise[3:0];
            ctrl_ff.multichannel_align_enable <= realign_mc_ff[7:4];
            ctrl_ff.alignment_sync_mode <= sync_mode_ff;
            ctrl_ff.fifo_ptr_reset <= nxt_ptr_reset;
            ctrl_ff.pair_resync <= trig_rise[9:8];
            ctrl_ff.group_resync <= trig_rise[10];
            ctrl_ff.xaui_link_machine <= resync_link_ff[RSY_XAUI] ? 4'hf
                : channel_link_machine_select;
        end
    end

    assign ctrl = ctrl_ff;

    // Checks
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_realign_rise;
        realign_mc_ff[0] && !trig_prev_ff[0];
    endsequence

    sequence s_one_pulse;
        ctrl.word_realign_pulse[0] ##1 !ctrl.word_realign_pulse[0];
    endsequence

    a_global_rx_pd:
        assert property (global_ff[GLB_RX_PD] |=> ctrl.rx_powerdown == 4'hf)
        else $error("global rx powerdown not applied");
    a_global_test:
        assert property (global_ff[GLB_TEST] |=> ctrl.test_mode_on == 4'hf)
        else $error("global test enable not applied");
    a_chan_test:
        assert property (!global_ff[GLB_TEST] |=> ctrl.test_mode_on == $past(channel_test_enable))
        else $error("channel test enable not followed");
    a_reserved_reset:
        assert property ($rose(aresetn) |-> global_ff[GLB_RES_HI:GLB_RES_LO] == 2'b11)
        else $error("reserved bits not one after reset");
    a_lock_gated:
        assert property (1'b1 |=> (ctrl.lock_indicator & ~$past(bsync_lock_ff[7:4])) == 4'h0)
        else $error("lock indicator set with reference lock");
    a_loop_out_off:
        assert property ((ctrl.serial_loopback_on & ctrl.hs_serial_out_enable) == 4'h0)
        else $error("serial output on during loopback");
    a_realign_pulse:
        assert property (s_realign_rise |=> s_one_pulse)
        else $error("realign pulse missing or too long");
    a_pair_resync:
        assert property ($rose(resync_link_ff[RSY_PAIR_CD]) |=> ctrl.fifo_ptr_reset[3:2] == 2'b11)
        else $error("pair resync missed channels");
    a_group_resync:
        assert property ($rose(resync_link_ff[RSY_GROUP]) |=> ctrl.fifo_ptr_reset == 4'hf ##1 !ctrl.group_resync)
        else $error("group resync wrong");
    a_xaui_select:
        assert property (resync_link_ff[RSY_XAUI] |=> ctrl.xaui_link_machine == 4'hf)
        else $error("xaui_link_machine_select not applied");
    a_write_resp:
        assert property (do_wr |=> s_axi_bvalid && (trig_prev_ff == $past(trig_now)))
        else $error("write response late");

    // Stored byte reaches ctrl two edges after the write lands
    sequence s_wr_bsync;
        do_wr && wlane_ff && awaddr_ff == ADDR_BSYNC_LOCK;
    endsequence

    sequence s_wr_loop;
        do_wr && wlane_ff && awaddr_ff == ADDR_LOOP_WALIGN;
    endsequence

    sequence s_wr_realign;
        do_wr && wlane_ff && awaddr_ff == ADDR_REALIGN_MC;
    endsequence

    sequence s_fifo_c_pulse;
        ctrl.fifo_ptr_reset[2] ##1 !ctrl.fifo_ptr_reset[2];
    endsequence

    a_test_sel_out:
        assert property (do_wr && wlane_ff && awaddr_ff == ADDR_TEST_SEL
            |=> ##1 ctrl.test_select_field == $past(wbyte_ff[TSEL_W-1:0], 2))
        else $error("test select not applied");
    a_byte_sync_out:
        assert property (s_wr_bsync |=> ##1 ctrl.byte_sync_enable == $past(wbyte_ff[3:0], 2))
        else $error("byte sync enable not applied");
    a_lock_src_out:
        assert property (s_wr_bsync |=> ##1 ctrl.pll_lock_source == $past(wbyte_ff[7:4], 2))
        else $error("lock source not applied");
    a_loopback_out:
        assert property (s_wr_loop |=> ##1 ctrl.serial_loopback_on == $past(wbyte_ff[3:0], 2))
        else $error("loopback not applied");
    a_align_dis_out:
        assert property (s_wr_loop |=> ##1 ctrl.word_align_disable == $past(wbyte_ff[7:4], 2))
        else $error("word align disable not applied");
    a_mc_align_out:
        assert property (s_wr_realign |=> ##1 ctrl.multichannel_align_enable == $past(wbyte_ff[7:4], 2))
        else $error("multichannel enable not applied");
    a_sync_mode_out:
        assert property (do_wr && wlane_ff && awaddr_ff == ADDR_SYNC_MODE
            |=> ##1 ctrl.alignment_sync_mode == $past(wbyte_ff, 2))
        else $error("sync mode not applied");
    a_single_resync:
        assert property ($rose(resync_link_ff[2]) |=> s_fifo_c_pulse)
        else $error("single resync pulse wrong");
    a_pair_ab_resync:
        assert property ($rose(resync_link_ff[RSY_PAIR_AB]) |=> ctrl.fifo_ptr_reset[1:0] == 2'b11 && ctrl.pair_resync[0])
        else $error("pair resync missed channels");
    a_unmapped_wr:
        assert property (do_wr && !wr_hit |=> s_axi_bvalid && s_axi_bresp == RESP_SLVERR)
        else $error("unmapped write not refused");
    a_unmapped_rd:
        assert property (s_axi_arvalid && s_axi_arready && !rd_hit
            |=> s_axi_rvalid && s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");

endmodule : sqc_regs
`default_nettype wire

// >>> verification/sqc_tb.sv
// Self-checking testbench for the quad transceiver control register bank
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import sqc_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [AW-1:0] s_axi_awaddr = '0;
    logic [AW-1:0] s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    // Per-channel levels stay fixed so every override shows against a known pattern
    logic [3:0] chn_pd = 4'h2;
    logic [3:0] chn_te = 4'h5;
    logic [3:0] chn_lm = 4'h9;
    logic [3:0] locked = 4'hf;
    sqc_ctrl_t ctrl;
    int n_errors = 0;
    int check_count = 0;
    int cycles = 0;
    int n_pulse = 0;
    logic [3:0] acc_re = '0;
    logic [3:0] acc_fp = '0;
    logic [1:0] acc_pr = '0;
    logic acc_gr = 1'b0;
    int clr_gen = 0;
    int clr_seen = 0;

    sqc_regs sqc_regs_i (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .channel_rx_powerdown(chn_pd),
        .channel_test_enable(chn_te), .channel_link_machine_select(chn_lm),
        .pll_locked_raw(locked), .ctrl(ctrl));

    always #12.5 aclk = ~aclk;

    // Pulse monitor: accumulates trigger pulses and counts cycles with any pulse high
    // Clears come as a generation count so only this block writes the tallies
    always @(posedge aclk) begin
        clr_seen <= clr_gen;
        if (clr_seen != clr_gen) begin
            acc_re <= 4'h0;
            acc_fp <= 4'h0;
            acc_pr <= 2'h0;
            acc_gr <= 1'b0;
            n_pulse <= 0;
        end else begin
            acc_re <= acc_re | ctrl.word_realign_pulse;
            acc_fp <= acc_fp | ctrl.fifo_ptr_reset;
            acc_pr <= acc_pr | ctrl.pair_resync;
            acc_gr <= acc_gr | ctrl.group_resync;
            if ((ctrl.word_realign_pulse | ctrl.fifo_ptr_reset) !== 4'h0 || ctrl.pair_resync !== 2'h0
                || ctrl.group_resync !== 1'b0) begin
                n_pulse <= n_pulse + 1;
            end
        end
    end

    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim

    // Hang guard, well above the few hundred cycles the sequence needs
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            end_sim();
        end
    end

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [AW-1:0] a, input logic [7:0] d, input logic [1:0] er);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) begin
                chk("bresp", 32'(s_axi_bresp), 32'(er));
                s_axi_bready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask : wr

    task automatic rchk(input logic [AW-1:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) begin
                chk("rdata", s_axi_rdata, exp);
                chk("rresp", 32'(s_axi_rresp), 32'(er));
                s_axi_rready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask : rchk

    task automatic settle;
        repeat (2) @(posedge aclk);
        #1;
    endtask : settle

    task automatic clr;
        clr_gen++;
    endtask : clr

    // Trigger only counts on a rising bit, so clear it first
    task automatic trig(input logic [AW-1:0] a, input logic [7:0] v);
        wr(a, 8'h00, RESP_OKAY);
        settle();
        clr();
        wr(a, v, RESP_OKAY);
        repeat (4) @(posedge aclk);
        #1;
    endtask : trig

    task automatic resync(input logic [7:0] v, input logic [3:0] fp, input logic [1:0] pr, input logic gr);
        trig(ADDR_RESYNC_LINK, v);
        chk("fifo_ptr_reset", 32'(acc_fp), 32'(fp));
        chk("pair_resync", 32'(acc_pr), 32'(pr));
        chk("group_resync", 32'(acc_gr), 32'(gr));
        chk("pulse_cycles", 32'(n_pulse), 32'h1);
    endtask : resync

    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(ADDR_GLOBAL, 32'h60, RESP_OKAY);
        rchk(ADDR_TEST_SEL, 32'h0, RESP_OKAY);
        rchk(ADDR_BSYNC_LOCK, 32'h0, RESP_OKAY);
        rchk(ADDR_LOOP_WALIGN, 32'h0, RESP_OKAY);
        rchk(ADDR_REALIGN_MC, 32'h0, RESP_OKAY);
        rchk(ADDR_SYNC_MODE, 32'h0, RESP_OKAY);
        rchk(ADDR_RESYNC_LINK, 32'h0, RESP_OKAY);
        $display("test reset_values finished");
        wr(ADDR_GLOBAL, 8'hff, RESP_OKAY);
        rchk(ADDR_GLOBAL, 32'hf0, RESP_OKAY);
        chk("rx_powerdown", 32'(ctrl.rx_powerdown), 32'hf);
        chk("test_mode_on", 32'(ctrl.test_mode_on), 32'hf);
        wr(ADDR_GLOBAL, 8'h00, RESP_OKAY);
        settle();
        chk("rx_powerdown", 32'(ctrl.rx_powerdown), 32'(chn_pd));
        chk("test_mode_on", 32'(ctrl.test_mode_on), 32'(chn_te));
        wr(ADDR_TEST_SEL, 8'h15, RESP_OKAY);
        rchk(ADDR_TEST_SEL, 32'h15, RESP_OKAY);
        chk("test_select", 32'(ctrl.test_select_field), 32'h15);
        // Lane 0 strobe low: accepted but nothing stored
        s_axi_wstrb <= 4'he;
        wr(ADDR_TEST_SEL, 8'h0a, RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        rchk(ADDR_TEST_SEL, 32'h15, RESP_OKAY);
        $display("test global_control finished");
        wr(ADDR_BSYNC_LOCK, 8'h53, RESP_OKAY);
        rchk(ADDR_BSYNC_LOCK, 32'h53, RESP_OKAY);
        chk("byte_sync", 32'(ctrl.byte_sync_enable), 32'h3);
        chk("lock_source", 32'(ctrl.pll_lock_source), 32'h5);
        chk("lock_indicator", 32'(ctrl.lock_indicator), 32'h5);
        rchk(ADDR_LOCK_STAT, 32'h5, RESP_OKAY);
        wr(ADDR_LOOP_WALIGN, 8'h96, RESP_OKAY);
        rchk(ADDR_LOOP_WALIGN, 32'h96, RESP_OKAY);
        chk("loopback", 32'(ctrl.serial_loopback_on), 32'h6);
        chk("hs_out_en", 32'(ctrl.hs_serial_out_enable), 32'h9);
        chk("align_dis", 32'(ctrl.word_align_disable), 32'h9);
        wr(ADDR_SYNC_MODE, {SYNC_QUAD, SYNC_TWIN, SYNC_NONE, SYNC_TWIN}, RESP_OKAY);
        settle();
        chk("sync_mode", 32'(ctrl.alignment_sync_mode), 32'h91);
        $display("test channel_fields finished");
        trig(ADDR_REALIGN_MC, 8'ha5);
        chk("realign", 32'(acc_re), 32'h5);
        chk("pulse_cycles", 32'(n_pulse), 32'h1);
        chk("mc_align", 32'(ctrl.multichannel_align_enable), 32'ha);
        clr();
        wr(ADDR_REALIGN_MC, 8'ha5, RESP_OKAY);
        settle();
        chk("pulse_cycles", 32'(n_pulse), 32'h0);
        resync(8'h04, 4'h4, 2'h0, 1'b0);
        resync(8'h20, 4'hc, 2'h2, 1'b0);
        resync(8'h40, 4'hf, 2'h0, 1'b1);
        resync(8'h90, 4'h3, 2'h1, 1'b0);
        chk("xaui", 32'(ctrl.xaui_link_machine), 32'hf);
        wr(ADDR_RESYNC_LINK, 8'h00, RESP_OKAY);
        settle();
        chk("xaui", 32'(ctrl.xaui_link_machine), 32'(chn_lm));
        $display("test triggers finished");
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(ADDR_GLOBAL, 32'h60, RESP_OKAY);
        rchk(ADDR_TEST_SEL, 32'h0, RESP_OKAY);
        $display("test mid_reset finished");
        wr(20'h00100, 8'hff, RESP_SLVERR);
        rchk(20'h00100, 32'h0, RESP_SLVERR);
        $display("test unmapped finished");
        end_sim();
    end
endmodule : testbench
`default_nettype wire
